// >>> design/hpss_pkg.sv
// Constants shared by the host port select and strap block.
// Assumes a 100 MHz core clock; the link clock is a free-running
// peripheral clock of its own.
package hpss_pkg;

  // Host interfaces that own a transmit-pending indicator.
  localparam int N_IF = 3;
  localparam int IF_UART = 0;
  localparam int IF_I2C = 1;
  localparam int IF_SPI = 2;

  // Core clock rate and UART default rate.
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_DEFAULT = 9600;
  localparam int BAUD_W = 16;

  // Cycles that the strap synchronisers settle before capture.
  localparam logic [5:0] SETTLE_CYC = 6'h03;
  // Cycles between capturing the select and declaring it valid; covers
  // more than two link clock periods so both crossed bits agree.
  localparam logic [5:0] LINK_GAP_CYC = 6'h20;

  // Flash strap order: data0, data1, data2, data3, clock, select_n in
  // bits 0..5. Open pins read high through the internal pull-ups.
  localparam logic [5:0] STRAP_DCDC = 6'h09;

  // One-time converter enable message header bytes.
  localparam logic [7:0] OTP_MSG_SYNC1 = 8'hb5;
  localparam logic [7:0] OTP_MSG_SYNC2 = 8'h62;
  localparam logic [7:0] OTP_MSG_CLASS = 8'h06;
  localparam logic [7:0] OTP_MSG_ID = 8'h41;

  typedef enum logic [2:0] {
    ST_SETTLE = 3'b001,
    ST_HOLD = 3'b010,
    ST_RUN = 3'b100
  } hpss_state_t;

endpackage

// >>> design/hpss_top.sv
// Host port select, transmit-pending indicators and strap capture.
// Assumes the UART, I2C and SPI serial engines run on LINK_CLK_I and
// that queue levels and configuration strobes come from CLK_I logic.
`timescale 1ns/1ns
`default_nettype none
module hpss_top #(
  parameter int LVL_W = 10,
  parameter logic [15:0] BAUD_DIV_RST =
    16'(hpss_pkg::CLK_HZ / hpss_pkg::BAUD_DEFAULT)
) (
  input wire logic CLK_I,
  input wire logic LINK_CLK_I,
  input wire logic NRST_I,
  input wire logic SEL_STRAP_I,
  input wire logic QUAD_FLASH_DATA0_I,
  input wire logic QUAD_FLASH_DATA1_I,
  input wire logic QUAD_FLASH_DATA2_I,
  input wire logic QUAD_FLASH_DATA3_I,
  input wire logic QUAD_FLASH_CLOCK_I,
  input wire logic QUAD_FLASH_SELECT_N_I,
  input wire logic OTP_FUSE_I,
  input wire logic OTP_REQ_I,
  input wire logic PSAVE_I,
  input wire logic BAUD_WR_I,
  input wire logic [hpss_pkg::BAUD_W-1:0] BAUD_DIV_I,
  input wire logic TXR_CFG_WR_I,
  input wire logic [hpss_pkg::N_IF-1:0] TXR_EN_I,
  input wire logic [hpss_pkg::N_IF-1:0] TXR_POL_I,
  input wire logic [hpss_pkg::N_IF-1:0][LVL_W-1:0] TXR_THR_I,
  input wire logic [hpss_pkg::N_IF-1:0][LVL_W-1:0] TXQ_LEVEL_I,
  input wire logic HOST_P1_I,
  input wire logic HOST_P2_I,
  input wire logic HOST_P3_I,
  input wire logic UART_TXD_I,
  input wire logic SPI_MISO_I,
  input wire logic I2C_SCL_LOW_I,
  input wire logic I2C_SDA_LOW_I,
  output logic HOST_P0_O,
  output logic HOST_P0_OE_O,
  output logic HOST_P2_O,
  output logic HOST_P2_OE_O,
  output logic HOST_P3_O,
  output logic HOST_P3_OE_O,
  output logic UART_RXD_O,
  output logic I2C_SCL_O,
  output logic I2C_SDA_O,
  output logic SPI_MOSI_O,
  output logic SPI_SCK_O,
  output logic SPI_CS_N_O,
  output logic UART_EN_O,
  output logic I2C_EN_O,
  output logic SPI_EN_O,
  output logic DCDC_EN_O,
  output logic DCDC_FROM_OTP_O,
  output logic OTP_BURN_O,
  output logic OTP_ACK_O,
  output logic WAKE_O,
  output logic [hpss_pkg::BAUD_W-1:0] UART_DIV_O,
  output logic [hpss_pkg::N_IF-1:0] TXR_O
);
  import hpss_pkg::*;

  typedef struct packed {
    hpss_state_t st;
    logic [5:0] cnt;
    logic dsel_s1;
    logic dsel_s2;
    logic [5:0] qf_s1;
    logic [5:0] qf_s2;
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic sel_spi;
    logic strap_ok;
    logic otp_seen;
    logic uart_en;
    logic i2c_en;
    logic spi_en;
    logic dcdc;
    logic [N_IF-1:0] txr_en;
    logic [N_IF-1:0] txr_pol;
    logic [N_IF-1:0][LVL_W-1:0] thr;
    logic [N_IF-1:0] txr;
    logic [BAUD_W-1:0] baud;
    logic wake;
    logic burn;
    logic ack;
  } hpss_core_t;

  typedef struct packed {
    logic sv_s1;
    logic sv_s2;
    logic ss_s1;
    logic ss_s2;
    logic rx_s1;
    logic rx_s2;
    logic ck_s1;
    logic ck_s2;
    logic dt_s1;
    logic dt_s2;
    logic tx;
    logic tx_oe;
    logic ck_oe;
    logic dt_oe;
    logic lo;
    logic urxd;
    logic scl;
    logic sda;
    logic mosi;
    logic sck;
    logic csn;
  } hpss_link_t;

  hpss_core_t c_r;
  hpss_core_t c_nxt;
  hpss_link_t l_r;
  hpss_link_t l_nxt;
  logic capture;
  logic run;
  logic [N_IF-1:0] if_live;

  assign capture = (c_r.st == ST_SETTLE) && (c_r.cnt == SETTLE_CYC);
  assign run = (c_r.st == ST_RUN);

  // Core clock domain.
  always_comb begin
    c_nxt = c_r;
    c_nxt.dsel_s1 = SEL_STRAP_I;
    c_nxt.dsel_s2 = c_r.dsel_s1;
    c_nxt.qf_s1 = {QUAD_FLASH_SELECT_N_I, QUAD_FLASH_CLOCK_I,
      QUAD_FLASH_DATA3_I, QUAD_FLASH_DATA2_I, QUAD_FLASH_DATA1_I,
      QUAD_FLASH_DATA0_I};
    c_nxt.qf_s2 = c_r.qf_s1;
    c_nxt.rx_s1 = HOST_P1_I;
    c_nxt.rx_s2 = c_r.rx_s1;
    c_nxt.rx_s3 = c_r.rx_s2;
    c_nxt.cnt = c_r.cnt + 6'h01;
    case (c_r.st)
      ST_SETTLE: begin
        if (capture) begin
          // The straps and the fuse are read once here and then held.
          c_nxt.sel_spi = ~c_r.dsel_s2;
          c_nxt.strap_ok = (c_r.qf_s2 == STRAP_DCDC);
          c_nxt.otp_seen = OTP_FUSE_I;
          c_nxt.cnt = 6'h00;
          c_nxt.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (c_r.cnt == LINK_GAP_CYC) begin
          c_nxt.st = ST_RUN;
        end
      end
      ST_RUN: begin
        c_nxt.cnt = c_r.cnt;
      end
      default: begin
        c_nxt.st = ST_SETTLE;
        c_nxt.cnt = 6'h00;
      end
    endcase
    c_nxt.uart_en = run & ~c_r.sel_spi;
    c_nxt.i2c_en = run & ~c_r.sel_spi;
    c_nxt.spi_en = run & c_r.sel_spi;
    c_nxt.dcdc = run & (c_r.strap_ok | c_r.otp_seen);
    // The burn only reaches the fuse; the new setting shows after reset.
    c_nxt.burn = run & OTP_REQ_I;
    c_nxt.ack = c_r.burn;
    if (BAUD_WR_I) begin
      c_nxt.baud = BAUD_DIV_I;
    end
    if (TXR_CFG_WR_I) begin
      c_nxt.txr_en = TXR_EN_I;
      c_nxt.txr_pol = TXR_POL_I;
      c_nxt.thr = TXR_THR_I;
    end
    for (int i = 0; i < N_IF; i++) begin
      // A disabled or unmapped indicator rests low whatever its polarity.
      if (c_r.txr_en[i] && if_live[i]) begin
        c_nxt.txr[i] = c_r.txr_pol[i] ~^
          ((TXQ_LEVEL_I[i] >= c_r.thr[i]) &&
           (TXQ_LEVEL_I[i] != '0));
      end else begin
        c_nxt.txr[i] = 1'b0;
      end
    end
    // The compare uses the second and third stages, never the first.
    c_nxt.wake = c_r.uart_en & PSAVE_I & (c_r.rx_s2 ^ c_r.rx_s3);
  end

  assign if_live = {c_r.spi_en, c_r.i2c_en, c_r.uart_en};

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      c_r <= '0;
      c_r.st <= ST_SETTLE;
      // The receive pin idles high; starting the chain high keeps a
      // false level change from following reset.
      c_r.rx_s1 <= 1'b1;
      c_r.rx_s2 <= 1'b1;
      c_r.rx_s3 <= 1'b1;
      c_r.baud <= BAUD_DIV_RST;
    end else begin
      c_r <= c_nxt;
    end
  end

  // Link clock domain. The select crosses as two levels; the valid
  // level trails the select by LINK_GAP_CYC plus two core cycles, so they never disagree.
  always_comb begin
    logic spi;
    logic ser;
    spi = 1'b0;
    ser = 1'b0;
    l_nxt = l_r;
    // Both enables are flops and at most one of them ever rises, so the
    // OR cannot glitch on its way into the link domain.
    l_nxt.sv_s1 = c_r.uart_en | c_r.spi_en;
    l_nxt.sv_s2 = l_r.sv_s1;
    l_nxt.ss_s1 = c_r.sel_spi;
    l_nxt.ss_s2 = l_r.ss_s1;
    l_nxt.rx_s1 = HOST_P1_I;
    l_nxt.rx_s2 = l_r.rx_s1;
    l_nxt.ck_s1 = HOST_P2_I;
    l_nxt.ck_s2 = l_r.ck_s1;
    l_nxt.dt_s1 = HOST_P3_I;
    l_nxt.dt_s2 = l_r.dt_s1;
    spi = l_r.sv_s2 & l_r.ss_s2;
    ser = l_r.sv_s2 & ~l_r.ss_s2;
    // The transmit pin is push-pull for the UART; for SPI it is driven
    // only while the host holds the chip select low.
    l_nxt.tx = spi ? SPI_MISO_I : UART_TXD_I;
    l_nxt.tx_oe = ser | (spi & ~l_r.dt_s2);
    l_nxt.ck_oe = ser & I2C_SCL_LOW_I;
    l_nxt.dt_oe = ser & I2C_SDA_LOW_I;
    // Engines of the unselected group see idle lines only.
    l_nxt.urxd = ser ? l_r.rx_s2 : 1'b1;
    l_nxt.scl = ser ? l_r.ck_s2 : 1'b1;
    l_nxt.sda = ser ? l_r.dt_s2 : 1'b1;
    l_nxt.mosi = spi ? l_r.rx_s2 : 1'b0;
    l_nxt.sck = spi ? l_r.ck_s2 : 1'b0;
    l_nxt.csn = spi ? l_r.dt_s2 : 1'b1;
    l_nxt.lo = 1'b0;
  end

  always_ff @(posedge LINK_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      l_r <= '0;
      l_r.urxd <= 1'b1;
      l_r.scl <= 1'b1;
      l_r.sda <= 1'b1;
      l_r.csn <= 1'b1;
    end else begin
      l_r <= l_nxt;
    end
  end

  // The UART has no handshake or clocked-mode pins at all.
  assign HOST_P0_O = l_r.tx;
  assign HOST_P0_OE_O = l_r.tx_oe;
  assign HOST_P2_O = l_r.lo;
  assign HOST_P2_OE_O = l_r.ck_oe;
  assign HOST_P3_O = l_r.lo;
  assign HOST_P3_OE_O = l_r.dt_oe;
  assign UART_RXD_O = l_r.urxd;
  assign I2C_SCL_O = l_r.scl;
  assign I2C_SDA_O = l_r.sda;
  assign SPI_MOSI_O = l_r.mosi;
  assign SPI_SCK_O = l_r.sck;
  assign SPI_CS_N_O = l_r.csn;
  assign UART_EN_O = c_r.uart_en;
  assign I2C_EN_O = c_r.i2c_en;
  assign SPI_EN_O = c_r.spi_en;
  assign DCDC_EN_O = c_r.dcdc;
  assign DCDC_FROM_OTP_O = c_r.otp_seen;
  assign OTP_BURN_O = c_r.burn;
  assign OTP_ACK_O = c_r.ack;
  assign WAKE_O = c_r.wake;
  assign UART_DIV_O = c_r.baud;
  assign TXR_O = c_r.txr;

  AST_SPI_EXCL: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    !(SPI_EN_O && (UART_EN_O || I2C_EN_O)))
    else $error("SPI active together with UART or I2C");

  AST_SEL_HIGH: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (capture && c_r.dsel_s2) |-> ##[1:40] (UART_EN_O && I2C_EN_O))
    else $error("Select high did not enable UART and I2C");

  AST_SEL_LOW: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (capture && !c_r.dsel_s2) |-> ##[1:40] (SPI_EN_O && !UART_EN_O))
    else $error("Select low did not enable SPI alone");

  AST_HOLD: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (run && $past(run) && $past(run, 2)) |->
      ($stable(SPI_EN_O) && $stable(UART_EN_O) && $stable(DCDC_EN_O)))
    else $error("Port mapping or converter changed after capture");

  AST_DCDC: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (capture && c_r.qf_s2 == STRAP_DCDC) |-> ##[1:40] DCDC_EN_O)
    else $error("Flash strap pattern did not enable converter");

  AST_OTP_ACK: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (run && OTP_REQ_I) |=> OTP_BURN_O ##1 OTP_ACK_O)
    else $error("OTP request not burned and acknowledged");

  AST_OTP_IDLE: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (!run) |=> !OTP_BURN_O)
    else $error("OTP burn issued before the mapping was running");

  AST_TXR_OFF: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (TXR_O[IF_UART] || TXR_O[IF_I2C] || TXR_O[IF_SPI]) |->
      ($past(c_r.txr_en) != '0))
    else $error("Indicator active while disabled");

  AST_TXR_HI: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (c_r.txr_en[IF_UART] && c_r.txr_pol[IF_UART] && UART_EN_O &&
     TXQ_LEVEL_I[IF_UART] >= c_r.thr[IF_UART] &&
     TXQ_LEVEL_I[IF_UART] != '0) |=> TXR_O[IF_UART])
    else $error("Active-high UART indicator missed threshold");

  AST_TXR_SPI: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (!SPI_EN_O) |=> !TXR_O[IF_SPI])
    else $error("SPI indicator active while SPI unmapped");

  AST_BAUD: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    BAUD_WR_I |=> (UART_DIV_O == $past(BAUD_DIV_I)))
    else $error("Baud divisor not loaded");

  AST_WAKE: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    WAKE_O |-> ($past(PSAVE_I) && $past(UART_EN_O)))
    else $error("Wake without power save in UART mode");

endmodule
`default_nettype wire

// >>> sim/hpss_host_model.sv
// Host CPU side of three of the four shared pins: P1, P2 and P3.
// Assumes pull-ups on the open-drain lines and a free-running link clock.
`timescale 1ns/1ns
`default_nettype none
module hpss_host_model (
  input wire logic link_clk_i,
  input wire logic rx_i,
  input wire logic scl_i,
  input wire logic cs_i,
  input wire logic p2_oe_i,
  input wire logic p3_oe_i,
  output logic p1_o,
  output logic p2_o,
  output logic p3_o
);
  // The host drives its receive line just after its own clock edge.
  always @(posedge link_clk_i) begin
    p1_o <= #2 rx_i;
  end
  // A pulled-up wire goes low as soon as any party pulls it.
  assign p2_o = scl_i & ~p2_oe_i;
  assign p3_o = cs_i & ~p3_oe_i;
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the host port select and strap block.
// Assumes the host model on the shared pins and a 125 ns link clock.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import hpss_pkg::*;
  logic clk = 0, lclk = 0, nrst = 0, sel = 1, fuse = 0, req = 0;
  logic psave = 0, bwr = 0, cwr = 0, rx = 1, scl = 1, cs = 1;
  logic utxd = 1, miso = 0, scl_lo = 0, sda_lo = 0;
  logic [5:0] fl = 6'h3f;
  logic [15:0] bdiv = 16'h0, div;
  logic [2:0] en = 3'h0, pol = 3'h0, txr;
  logic [2:0][9:0] thr = 30'h0, lvl = 30'h0;
  logic p1, p2, p3, p0, p0e, p2o, p2e, p3o, p3e, urx, iscl, isda;
  logic mosi, sck, csn, uen, ien, sen, dc, dco, burn, ack, wake;
  logic [31:0] seed = 32'h59, r;
  int failures = 0, check_count = 0;
  hpss_top hpss_top_i (
    .CLK_I(clk), .LINK_CLK_I(lclk), .NRST_I(nrst), .SEL_STRAP_I(sel),
    .QUAD_FLASH_DATA0_I(fl[0]), .QUAD_FLASH_DATA1_I(fl[1]),
    .QUAD_FLASH_DATA2_I(fl[2]), .QUAD_FLASH_DATA3_I(fl[3]),
    .QUAD_FLASH_CLOCK_I(fl[4]), .QUAD_FLASH_SELECT_N_I(fl[5]),
    .OTP_FUSE_I(fuse), .OTP_REQ_I(req), .PSAVE_I(psave), .BAUD_WR_I(bwr),
    .BAUD_DIV_I(bdiv), .TXR_CFG_WR_I(cwr), .TXR_EN_I(en), .TXR_POL_I(pol),
    .TXR_THR_I(thr), .TXQ_LEVEL_I(lvl), .HOST_P1_I(p1), .HOST_P2_I(p2),
    .HOST_P3_I(p3), .UART_TXD_I(utxd), .SPI_MISO_I(miso),
    .I2C_SCL_LOW_I(scl_lo), .I2C_SDA_LOW_I(sda_lo), .HOST_P0_O(p0),
    .HOST_P0_OE_O(p0e), .HOST_P2_O(p2o), .HOST_P2_OE_O(p2e),
    .HOST_P3_O(p3o), .HOST_P3_OE_O(p3e), .UART_RXD_O(urx),
    .I2C_SCL_O(iscl), .I2C_SDA_O(isda), .SPI_MOSI_O(mosi), .SPI_SCK_O(sck),
    .SPI_CS_N_O(csn), .UART_EN_O(uen), .I2C_EN_O(ien), .SPI_EN_O(sen),
    .DCDC_EN_O(dc), .DCDC_FROM_OTP_O(dco), .OTP_BURN_O(burn),
    .OTP_ACK_O(ack), .WAKE_O(wake), .UART_DIV_O(div), .TXR_O(txr));
  hpss_host_model hpss_host_model_i (.link_clk_i(lclk), .rx_i(rx),
    .scl_i(scl), .cs_i(cs), .p2_oe_i(p2e), .p3_oe_i(p3e), .p1_o(p1),
    .p2_o(p2), .p3_o(p3));
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #3;
    forever begin
      #62 lclk = 1;
      #63 lclk = 0;
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [2:0] txr_exp(input logic u);
    for (int i = 0; i < 3; i++) begin
      txr_exp[i] = en[i] && (u ? i != IF_SPI : i == IF_SPI)
        && (pol[i] == (lvl[i] >= thr[i] && lvl[i] != 0));
    end
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic lcyc(input int n);
    repeat (n) @(posedge lclk);
    cyc(1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic boot(input logic s, input logic [5:0] f, input logic z);
    nrst = 0;
    sel = s;
    fl = f;
    fuse = z;
    cyc(16);
    nrst = 1;
    cyc(10);
    // Straps move after capture; the mapping must not follow them.
    sel = ~s;
    fl = ~f;
    cyc(90);
    chk({uen, ien, sen}, {s, s, ~s}, "enables");
    chk(dc, z | (f == STRAP_DCDC), "converter");
    chk(dco, z, "fuse");
    chk(txr, 3'h0, "indicators");
    chk(div, 16'(CLK_HZ / BAUD_DEFAULT), "divisor");
  endtask
  task automatic txr_run(input logic u);
    for (int k = 0; k < 30; k++) begin
      r = xs();
      cwr = 1;
      en = r[2:0];
      pol = r[5:3];
      for (int i = 0; i < 3; i++) begin
        thr[i] = 10'(r[6+4*i +: 4]);
        lvl[i] = k < 3 ? thr[i] : 10'(r[18+4*i +: 4]);
      end
      cyc(1);
      cwr = 0;
      cyc(2);
      chk(txr, txr_exp(u), "indicator");
    end
  endtask
  task automatic wake_try(input logic e);
    logic seen;
    seen = 0;
    psave = 1;
    rx = ~rx;
    for (int n = 0; n < 40; n++) begin
      cyc(1);
      seen |= (wake === 1'b1);
    end
    psave = 0;
    chk(seen, e, "wake");
  endtask
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
  initial begin
    boot(1'b1, 6'h3f, 1'b0);
    rx = 0;
    utxd = 0;
    scl_lo = 1;
    sda_lo = 1;
    lcyc(6);
    chk({urx, p0, p0e, p2e, iscl, p3e, isda, p2o, p3o}, 16'h68,
        "uart pins");
    chk({mosi, sck, csn}, 16'h1, "spi idle");
    rx = 1;
    scl_lo = 0;
    sda_lo = 0;
    lcyc(6);
    wake_try(1'b1);
    wake_try(1'b1);
    bwr = 1;
    for (int k = 0; k < 6; k++) begin
      r = xs();
      bdiv = r[15:0];
      cyc(1);
      chk(div, r[15:0], "baud");
    end
    bwr = 0;
    cyc(3);
    chk(div, r[15:0], "baud hold");
    txr_run(1'b1);
    req = 1;
    cyc(1);
    req = 0;
    chk({burn, ack}, 16'h2, "burn");
    cyc(1);
    chk({burn, ack, dco}, 16'h2, "ack");
    $display("test uart mode done");
    boot(1'b0, STRAP_DCDC, 1'b0);
    cs = 0;
    miso = 1;
    rx = 1;
    scl = 0;
    lcyc(6);
    chk({csn, p0e, p0, urx, iscl, isda, mosi, sck}, 16'h7e,
        "spi pins");
    cs = 1;
    scl = 1;
    lcyc(6);
    chk({p0e, sck}, 16'h1, "miso release");
    wake_try(1'b0);
    txr_run(1'b0);
    $display("test spi mode done");
    boot(1'b1, 6'h0b, 1'b0);
    boot(1'b1, 6'h3f, 1'b1);
    $display("test strap done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
